/* verilog/csw_pkg.sv */
// Package for the compare and word shift unit: opcodes, field slices, widths.
// Assumes the pipeline passes the raw instruction word, which the unit decodes, and hands over operands.
package csw_pkg;

  // Configured general register width
  localparam int unsigned REG_W         = 64;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned IMM_W         = 16;
  localparam int unsigned SHAMT_W       = 5;
  localparam int unsigned IDX_W         = 5;
  localparam int unsigned INSN_W        = 32;

  // Instruction field positions
  localparam int unsigned OPC_HI        = 31;
  localparam int unsigned OPC_LO        = 26;
  localparam int unsigned FIRST_IDX_HI  = 25;
  localparam int unsigned FIRST_IDX_LO  = 21;
  localparam int unsigned SECOND_IDX_HI = 20;
  localparam int unsigned SECOND_IDX_LO = 16;
  localparam int unsigned DEST_IDX_HI   = 15;
  localparam int unsigned DEST_IDX_LO   = 11;
  localparam int unsigned SHAMT_HI      = 10;
  localparam int unsigned SHAMT_LO      = 6;
  localparam int unsigned FUNCT_HI      = 5;
  localparam int unsigned FUNCT_LO      = 0;
  localparam int unsigned IMM_HI        = 15;
  localparam int unsigned IMM_LO        = 0;

  // Primary opcodes
  localparam logic [5:0] OPC_REGFORM    = 6'h00;
  localparam logic [5:0] OPC_LT_IMM_S   = 6'h0A;
  localparam logic [5:0] OPC_LT_IMM_U   = 6'h0B;

  // Function codes under the register form opcode
  localparam logic [5:0] FN_SRL         = 6'h02;
  localparam logic [5:0] FN_SRA         = 6'h03;
  localparam logic [5:0] FN_SRA_VAR     = 6'h07;
  localparam logic [5:0] FN_LT_S        = 6'h2A;
  localparam logic [5:0] FN_LT_U        = 6'h2B;

  // Decoded operation
  typedef enum logic [2:0] {
    CSW_OP_NONE     = 3'b000,
    CSW_OP_LT_S     = 3'b001,
    CSW_OP_LT_U     = 3'b010,
    CSW_OP_LT_IMM_S = 3'b011,
    CSW_OP_LT_IMM_U = 3'b100,
    CSW_OP_SRA      = 3'b101,
    CSW_OP_SRA_VAR  = 3'b110,
    CSW_OP_SRL      = 3'b111
  } csw_op_e;

  // Result latency from issue to output, in core clock cycles
  localparam int unsigned RESULT_LAT    = 1;

endpackage : csw_pkg

/* verilog/csw_unit.sv */
// Compare and word shift execution slice: set-on-less-than and word right shifts.
// Assumes operands are read from the register file in the issue cycle and that
// the pipeline accepts one result per cycle with no back-pressure.
//
// How it works
// - Signed register compare gives one or zero
// - Compares never raise an overflow exception
// - Immediate sign-extended, signed compare, second index
// - Immediate sign-extended, then compared unsigned
// - Function 101011 opcode 000000: unsigned compare
// - Arithmetic right shift fills with bit 31
// - Variable shift uses low five bits only
// - Logical right shift fills zeros, sign-extends
// - Fixed shift count from instruction bits 10:6
// - Improper word inputs give no defined result
module csw_unit
  import csw_pkg::*;
(
  input  wire logic               i_core_clk,     // Core clock, 250 MHz
  input  wire logic               i_arst_n,       // Asynchronous reset, active low
  input  wire logic               i_clk_en,       // Freezes all state while low
  input  wire logic               i_issue_valid,  // Instruction presented this cycle
  input  wire logic [INSN_W-1:0]  i_insn,         // Instruction word
  input  wire logic [REG_W-1:0]   i_first_opnd,   // Value of first_operand_index register
  input  wire logic [REG_W-1:0]   i_second_opnd,  // Value of second_operand_index register
  output logic                    o_accept,       // Instruction belongs to this unit
  output logic                    o_res_valid,    // Result present
  output logic [REG_W-1:0]        o_res_data,     // Result for general_register write
  output logic [IDX_W-1:0]        o_res_dest,     // Destination register index
  output logic                    o_res_wr_en,    // Register write enable
  output logic                    o_res_overflow  // Integer overflow exception request
);

  // Decoded fields
  logic [5:0]         opc;        // Primary opcode
  logic [5:0]         funct;      // Function code
  logic [IDX_W-1:0]   second_idx; // second_operand_index
  logic [IDX_W-1:0]   dest_idx;   // Register form destination
  logic [SHAMT_W-1:0] shamt_fix;  // shift_amount_field
  logic [IMM_W-1:0]   imm;        // Raw immediate
  csw_op_e            op;         // Decoded operation

  // Datapath intermediates
  logic [REG_W-1:0]   imm_sx;     // Sign-extended immediate
  logic [REG_W-1:0]   cmp_b;      // Second compare operand
  logic               lt_s;       // Signed less-than
  logic               lt_u;       // Unsigned less-than
  logic [SHAMT_W-1:0] shamt;      // Chosen shift distance
  logic [WORD_W-1:0]  word_in;    // Low word being shifted
  logic [WORD_W-1:0]  word_out;   // Shifted word
  logic [IDX_W-1:0]   dest_d;     // Destination index next
  logic [REG_W-1:0]   res_d;      // Result next

  // Registered result; data outputs come straight from these flip-flops
  logic               valid_q;    // Result present, also the write enable
  logic [REG_W-1:0]   res_q;      // Result held until the next accepted issue
  logic [IDX_W-1:0]   dest_q;     // Destination held with the result

  // Field extraction
  // Slices only; the first index field is consumed by the register file
  assign opc        = i_insn[OPC_HI:OPC_LO];
  assign funct      = i_insn[FUNCT_HI:FUNCT_LO];
  assign second_idx = i_insn[SECOND_IDX_HI:SECOND_IDX_LO];
  assign dest_idx   = i_insn[DEST_IDX_HI:DEST_IDX_LO];
  assign shamt_fix  = i_insn[SHAMT_HI:SHAMT_LO];
  assign imm        = i_insn[IMM_HI:IMM_LO];

  // Decoder; unknown encodings are simply not accepted
  // Other pipes own those encodings, so raising an error here would be wrong
  // Zero fields of the register forms are not checked, which saves a wide compare
  always_comb begin
    op = CSW_OP_NONE;
    if (opc == OPC_REGFORM) begin
      case (funct)
        FN_LT_S:    op = CSW_OP_LT_S;
        FN_LT_U:    op = CSW_OP_LT_U;
        FN_SRA:     op = CSW_OP_SRA;
        FN_SRA_VAR: op = CSW_OP_SRA_VAR;
        FN_SRL:     op = CSW_OP_SRL;
        default:    op = CSW_OP_NONE;
      endcase
    end else if (opc == OPC_LT_IMM_S) begin
      op = CSW_OP_LT_IMM_S;
    end else if (opc == OPC_LT_IMM_U) begin
      op = CSW_OP_LT_IMM_U;
    end
  end

  // Handshake output may be combinational
  // It depends on i_issue_valid and decode only, so the pipeline sees it in the issue cycle
  assign o_accept = i_issue_valid && (op != CSW_OP_NONE);

  // Immediate is always sign-extended, even for the unsigned compare
  // Limitation: unsigned constants reach only both ends of the range
  assign imm_sx = {{(REG_W-IMM_W){imm[IMM_W-1]}}, imm};

  // Compare operand select: register or immediate
  assign cmp_b = ((op == CSW_OP_LT_IMM_S) || (op == CSW_OP_LT_IMM_U)) ? imm_sx : i_second_opnd;

  // Comparators, no subtract so no overflow term exists at all
  // Both views share the operands; only the weight of the sign bit differs
  assign lt_s = $signed(i_first_opnd) < $signed(cmp_b);
  assign lt_u = i_first_opnd < cmp_b;

  // Shift distance: variable form reads only the low five bits
  assign shamt = (op == CSW_OP_SRA_VAR) ? i_first_opnd[SHAMT_W-1:0] : shamt_fix;

  // Only the low word is used; upper bits of an improper word are ignored
  assign word_in = i_second_opnd[WORD_W-1:0];

  // Word shifter, shared by all three shift forms
  // One arithmetic shifter plus a logical path keeps the barrel narrow: only
  // the low word moves, the upper half is rebuilt from bit 31 afterwards
  always_comb begin
    if (op == CSW_OP_SRL) begin
      word_out = word_in >> shamt;
    end else begin
      word_out = WORD_W'($signed(word_in) >>> shamt);
    end
  end

  // Result mux and destination select
  // Immediate forms name their destination in the second index field,
  // register forms in the destination field
  always_comb begin
    res_d  = '0;
    dest_d = dest_idx;
    case (op)
      CSW_OP_LT_S:     res_d = {{(REG_W-1){1'b0}}, lt_s};
      CSW_OP_LT_U:     res_d = {{(REG_W-1){1'b0}}, lt_u};
      CSW_OP_LT_IMM_S: begin
        res_d  = {{(REG_W-1){1'b0}}, lt_s};
        dest_d = second_idx;
      end
      CSW_OP_LT_IMM_U: begin
        res_d  = {{(REG_W-1){1'b0}}, lt_u};
        dest_d = second_idx;
      end
      CSW_OP_SRA, CSW_OP_SRA_VAR, CSW_OP_SRL: begin
        // Word result is sign-extended into the full register
        res_d = {{(REG_W-WORD_W){word_out[WORD_W-1]}}, word_out};
      end
      default:         res_d = '0;
    endcase
  end

  // Valid pipeline register
  // Loaded every enabled cycle so a result lasts one cycle unless another
  // issue follows; a low enable freezes it together with the data
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_q <= 1'b0;
    end else if (i_clk_en) begin
      valid_q <= o_accept;
    end
  end

  // Data pipeline register, loaded only on an accepted instruction
  // Holding the old value between results avoids toggling the write-back bus
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_q  <= '0;
      dest_q <= '0;
    end else if (i_clk_en && o_accept) begin
      res_q  <= res_d;
      dest_q <= dest_d;
    end
  end

  // Outputs; nothing here can trap, so the overflow request is tied low
  assign o_res_valid    = valid_q;
  assign o_res_data     = res_q;
  assign o_res_dest     = dest_q;
  assign o_res_wr_en    = valid_q;
  assign o_res_overflow = 1'b0;

  // Checks, all on the core clock and quiet while reset is low
  // Issue events are named sequences so the properties read as cause and effect
  sequence issue_lt_s_s;
    o_accept && i_clk_en && (opc == OPC_REGFORM) && (funct == FN_LT_S);
  endsequence

  sequence issue_imm_s;
    o_accept && i_clk_en && (opc == OPC_LT_IMM_S);
  endsequence

  // Any of the four compares taken this cycle
  sequence issue_cmp_s;
    o_accept && i_clk_en && ((op == CSW_OP_LT_S) || (op == CSW_OP_LT_U)
      || (op == CSW_OP_LT_IMM_S) || (op == CSW_OP_LT_IMM_U));
  endsequence

  // Any of the three word shifts taken this cycle
  sequence issue_shift_s;
    o_accept && i_clk_en
      && ((op == CSW_OP_SRA) || (op == CSW_OP_SRA_VAR) || (op == CSW_OP_SRL));
  endsequence

  // A register form compare or shift taken this cycle
  sequence issue_reg_form_s;
    o_accept && i_clk_en && (opc == OPC_REGFORM);
  endsequence

  // Immediate unsigned compare taken this cycle
  sequence issue_imm_u_s;
    o_accept && i_clk_en && (opc == OPC_LT_IMM_U);
  endsequence

  lt_signed_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_lt_s_s |=> o_res_valid
      && (o_res_data == {63'h0, $past($signed(i_first_opnd) < $signed(i_second_opnd))}))
    else $error("signed compare result wrong");

  no_overflow_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_res_valid |-> !o_res_overflow)
    else $error("compare raised overflow");

  imm_signed_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_imm_s |=> (o_res_dest == $past(second_idx))
      && (o_res_data == {63'h0, $past($signed(i_first_opnd)
        < $signed({{48{imm[15]}}, imm}))}))
    else $error("signed immediate compare wrong");

  // Negative immediates only: a zero-extended constant would flip these results
  imm_unsigned_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (opc == OPC_LT_IMM_U) && imm[15])
      |=> (o_res_data == {63'h0, $past(i_first_opnd < {{48{imm[15]}}, imm})}))
    else $error("unsigned immediate not sign-extended");

  // Immediate unsigned compare also writes the second index register
  imm_u_dest_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_imm_u_s |=> (o_res_dest == $past(second_idx)))
    else $error("unsigned immediate destination wrong");

  lt_unsigned_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (opc == OPC_REGFORM) && (funct == 6'h2B))
      |=> (o_res_data == {63'h0, $past(i_first_opnd < i_second_opnd)}))
    else $error("unsigned compare wrong");

  sra_fill_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (op == CSW_OP_SRA) && i_second_opnd[31] && (shamt_fix != 5'h0))
      |=> o_res_data[63] && o_res_data[31] && o_res_data[30])
    else $error("arithmetic shift lost sign");

  var_low_bits_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (op == CSW_OP_SRA_VAR)) |=> (o_res_data[31:0]
      == $past(32'($signed(i_second_opnd[31:0]) >>> i_first_opnd[4:0]))))
    else $error("variable shift distance wrong");

  srl_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (op == CSW_OP_SRL) && (shamt_fix != 5'h0))
      |=> (o_res_data[63:31] == 33'h0))
    else $error("logical shift not zero filled");

  fixed_count_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (op == CSW_OP_SRL))
      |=> (o_res_data[31:0] == ($past(i_second_opnd[31:0]) >> $past(i_insn[10:6]))))
    else $error("fixed shift count wrong");

  wr_enable_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en) |=> (o_res_valid && o_res_wr_en))
    else $error("result write not enabled");

  // Compare results carry a single meaningful bit
  lt_upper_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_cmp_s |=> (o_res_data[63:1] == 63'h0))
    else $error("compare upper bits not zero");

  // Compares never ask for an overflow trap after they complete
  cmp_no_trap_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_cmp_s |=> !o_res_overflow)
    else $error("compare requested a trap");

  // Every word shift result is the low word sign-extended
  word_sext_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_shift_s |=> (o_res_data[63:32] == {32{o_res_data[31]}}))
    else $error("shift result not sign-extended");

  // Fixed arithmetic shift, exact value of the low word
  sra_exact_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (o_accept && i_clk_en && (op == CSW_OP_SRA)) |=> (o_res_data[31:0]
      == $past(32'($signed(i_second_opnd[31:0]) >>> i_insn[SHAMT_HI:SHAMT_LO]))))
    else $error("arithmetic shift value wrong");

  // The unsigned register compare encoding is always taken
  lt_u_decode_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_issue_valid && (opc == 6'h00) && (funct == 6'h2B)) |-> o_accept)
    else $error("unsigned compare not decoded");

  // Register forms write the destination field
  reg_dest_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    issue_reg_form_s |=> (o_res_dest == $past(i_insn[DEST_IDX_HI:DEST_IDX_LO])))
    else $error("register form destination wrong");

  // A low enable freezes the whole result, valid included
  freeze_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !i_clk_en |=> ($stable(o_res_valid) && $stable(o_res_data) && $stable(o_res_dest)))
    else $error("result changed while frozen");

  // An enabled cycle with no taken issue leaves no result behind
  idle_no_valid_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_clk_en && !o_accept) |=> !o_res_valid)
    else $error("result without an issue");

endmodule : csw_unit

/* verification/csw_pipe_model.sv */
// Pipeline-side model: register file that feeds the unit's operands.
// Assumes the bench owns the clock; results are written back when enabled.
module csw_pipe_model
  import csw_pkg::*;
(
  input  wire logic              i_core_clk,    // Core clock
  input  wire logic [INSN_W-1:0] i_insn,        // Issued word
  input  wire logic              i_wr_en,       // Write-back strobe
  input  wire logic [IDX_W-1:0]  i_wr_idx,      // Write-back index
  input  wire logic [REG_W-1:0]  i_wr_data,     // Write-back value
  output logic      [REG_W-1:0]  o_first_opnd,  // Operand by first index
  output logic      [REG_W-1:0]  o_second_opnd  // Operand by second index
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [REG_W-1:0] regs_q [32];  // Register file contents

  // Even entries hold sign-extended words so shifts stay defined
  initial begin
    for (int k = 0; k < 32; k++) begin
      regs_q[k] = 64'h9E37_79B9_7F4A_7C15 * 64'(k + 1);
      if (k % 2 == 0) regs_q[k] = {{32{regs_q[k][31]}}, regs_q[k][31:0]};
    end
    regs_q[1] = 64'h8000_0000_0000_0000;  // Most negative
    regs_q[2] = 64'hFFFF_FFFF_8000_0000;  // Most negative word
    regs_q[3] = 64'h7FFF_FFFF_FFFF_FFFF;  // Most positive
    regs_q[4] = 64'h0;                    // Zero
  end

  // Write-back; results are always words, so even entries stay words
  always @(posedge i_core_clk) begin
    if (i_wr_en) regs_q[i_wr_idx] <= i_wr_data;
  end

  // Operand reads, same cycle as the issue
  assign o_first_opnd  = regs_q[i_insn[FIRST_IDX_HI:FIRST_IDX_LO]];
  assign o_second_opnd = regs_q[i_insn[SECOND_IDX_HI:SECOND_IDX_LO]];
endmodule : csw_pipe_model

/* verification/csw_unit_tb.sv */
// Self-checking bench for the compare and word shift unit.
// Assumes one-cycle result latency and freeze while the enable is low.
module csw_unit_tb
  import csw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk, rst_n, en, vld, acc, ev;  // Stimulus and expectation
  logic [31:0]       w;                             // Instruction word
  logic [63:0]       a, b, ed;                      // Operands, expected data
  logic [4:0]        edst;                          // Expected destination
  logic              res_valid, wr_en, ovf;         // Design outputs
  logic [63:0]       res_data;
  logic [4:0]        res_dest;
  int                err_total, checks, k, c;
  logic [11:0]       ops [8];                       // Opcode and function table
  logic [15:0]       imms [4];                      // Immediate corners

  csw_unit csw_unit_i (.i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(en),
    .i_issue_valid(vld), .i_insn(w), .i_first_opnd(a), .i_second_opnd(b),
    .o_accept(acc), .o_res_valid(res_valid), .o_res_data(res_data),
    .o_res_dest(res_dest), .o_res_wr_en(wr_en), .o_res_overflow(ovf));

  csw_pipe_model csw_pipe_model_i (.i_core_clk(clk), .i_insn(w), .i_wr_en(wr_en & res_valid),
    .i_wr_idx(res_dest), .i_wr_data(res_data), .o_first_opnd(a), .o_second_opnd(b));

  // Reference result worked out from the word and both operands
  function automatic logic [63:0] ref_res(logic [31:0] x, logic [63:0] p, logic [63:0] q);
    logic [63:0] imm;
    logic [31:0] t;
    imm = {{48{x[15]}}, x[15:0]};
    if (x[31:26] == OPC_LT_IMM_S) return {63'h0, $signed(p) < $signed(imm)};
    if (x[31:26] == OPC_LT_IMM_U) return {63'h0, p < imm};
    case (x[5:0])
      FN_LT_S:    return {63'h0, $signed(p) < $signed(q)};
      FN_LT_U:    return {63'h0, p < q};
      FN_SRA:     t = $signed(q[31:0]) >>> x[10:6];
      FN_SRA_VAR: t = $signed(q[31:0]) >>> p[4:0];
      default:    t = q[31:0] >> x[10:6];
    endcase
    return {{32{t[31]}}, t};
  endfunction : ref_res

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Free-running core clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog, well past the expected run length
  initial begin
    #20000;
    err_total++;
    conclude;
  end

  // Main sequence: random issues with corner immediates and shift counts
  initial begin
    k = $urandom(32'h86F484D1);
    ops = '{{OPC_REGFORM, FN_LT_S}, {OPC_REGFORM, FN_LT_U}, {OPC_REGFORM, FN_SRA},
            {OPC_REGFORM, FN_SRA_VAR}, {OPC_REGFORM, FN_SRL}, {OPC_LT_IMM_S, 6'h00},
            {OPC_LT_IMM_U, 6'h00}, {OPC_REGFORM, 6'h21}};
    imms = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000};
    {rst_n, en, vld, w, ev, ed, edst} = '0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    for (int n = 0; n < 1000; n++) begin
      @(negedge clk);
      chk(res_valid, ev);
      chk(wr_en, ev);
      chk(res_data, ed);
      chk(res_dest, edst);
      chk(ovf, 0);
      k = $urandom % 8;
      c = $urandom % 4;
      w = $urandom;
      w[31:26] = ops[k][11:6];
      if (k < 5 || k == 7) w[5:0] = ops[k][5:0];
      if (k >= 2 && k <= 4) w[16] = 1'b0;  // Word-valued shift source
      if (k == 5 || k == 6) w[15:0] = imms[c];
      else if (c == 0) w[10:6] = 5'd31;
      else if (c == 1) w[10:6] = 5'd0;
      en = ($urandom % 8) != 0;
      vld = ($urandom % 8) != 0;
      rst_n = (n != 500);  // One mid-run reset pulse, checked at the next falling edge
      #1 chk(acc, vld && k < 7);
      if (!rst_n) {ev, ed, edst} = '0;
      if (en && rst_n) begin
        ev = vld && k < 7;
        if (ev) begin
          ed = ref_res(w, a, b);
          edst = (k == 5 || k == 6) ? w[20:16] : w[15:11];
        end
      end
    end
    conclude;
  end
endmodule : csw_unit_tb
